/* File: inc/mwcc_map.svh */
`ifndef MWCC_MAP_SVH
`define MWCC_MAP_SVH
// Register indices as printed; byte address is four times the index
`define MWCC_IDX_WAKE 6'h0c
`define MWCC_IDX_CSUM 6'h0d
`define MWCC_IDX_IRQ_STAT 6'h10
`define MWCC_IDX_IRQ_MASK 6'h11
`define MWCC_IDX_CTRL_STAT 6'h12
`define MWCC_REG_RESET 32'h0000_0000
// Wake control fields
`define MWCC_GUE_BIT 9
`define MWCC_WFS_BIT 6
`define MWCC_MPS_BIT 5
`define MWCC_WFE_BIT 2
`define MWCC_MPE_BIT 1
`define MWCC_WAKE_WMASK 32'h0000_0206
`define MWCC_WAKE_RMASK 32'h0000_0266
`define MWCC_WAKE_FLAGS 32'h0000_0060
// Checksum control fields
`define MWCC_TXE_BIT 16
`define MWCC_RXSEL_BIT 1
`define MWCC_RXE_BIT 0
`define MWCC_CSUM_MASK 32'h0001_0003
// Receive checksum start offsets in bytes
`define MWCC_RX_START_L2 8'h0e
`define MWCC_RX_START_L3 8'h00
// Interrupt bits
`define MWCC_IRQ_WF_BIT 0
`define MWCC_IRQ_MP_BIT 1
`define MWCC_IRQ_GU_BIT 2
`define MWCC_IRQ_MASK 32'h0000_0007
`define MWCC_HTRANS_NONSEQ 2'h2
`define MWCC_HTRANS_SEQ 2'h3
`define MWCC_HSIZE_WORD 3'h2
`endif

/* File: inc/mwcc_pkg.sv */
package mwcc_pkg;
    typedef logic [31:0] mwcc_word_t;
    typedef logic [5:0] mwcc_idx_t;
endpackage

/* File: rtl/mwcc_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mwcc_map.svh"

// How it works
// - In power save with global unicast wake enabled, a unicast frame raises the wake request.
// - A frame is global unicast when destination address bit 0 is zero.
// - A valid wake frame sets the wake-frame-seen flag, bit 6.
// - A valid magic packet sets the magic-packet-seen flag, bit 5.
// - Bit 2 enables wake frame detection against the filter match.
// - Bit 1 enables magic packet wake; clear means that mode is off.
// - Both registers are 32 bits and reset to zero.
// - Bit 16 enables the transmit checksum engine; zero bypasses it.
// - Bit 1 picks receive checksum start: byte 14 or layer-3 start.
// - Bit 0 enables the receive checksum engine; zero bypasses it.
module mwcc_regs (
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire mwcc_pkg::mwcc_word_t hwdata,
    output mwcc_pkg::mwcc_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receive event strobes from the MAC, same clock
    input wire logic rx_frame_done,
    input wire logic rx_dest_addr_bit0,
    input wire logic rx_wake_filter_match,
    input wire logic rx_magic_pkt_valid,
    // Power state and data path status, same clock
    input wire logic power_save,
    input wire logic tx_path_en,
    input wire logic rx_path_en,
    input wire logic auto_pad_strip,
    // Controls to the MAC
    output logic wake_request,
    output logic tx_csum_engine_en,
    output logic rx_csum_engine_en,
    output logic rx_csum_start_select,
    output logic [7:0] rx_csum_fixed_start,
    output logic irq
);
    import mwcc_pkg::*;

    mwcc_word_t wake_control_status;
    mwcc_word_t checksum_offload_control;
    mwcc_word_t irq_stat;
    mwcc_word_t irq_mask;
    logic wr_pend;
    mwcc_idx_t wr_idx;
    logic wake_frame_ev;
    logic magic_ev;
    logic unicast_ev;
    logic [2:0] ev_vec;
    logic [2:0] w1c;
    mwcc_word_t next_rdata;

    function automatic mwcc_idx_t word_index(input logic [31:0] a);
        word_index = a[7:2];
    endfunction

    // Wake word after a software write: enables taken, a one clears a flag
    function automatic mwcc_word_t wake_merge(input mwcc_word_t old, input mwcc_word_t d);
        wake_merge = (d & `MWCC_WAKE_WMASK) | (old & `MWCC_WAKE_FLAGS & ~d);
    endfunction

    wire logic addr_phase = hsel && hready && htrans[1] && (hsize == `MWCC_HSIZE_WORD);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Write address capture; data lands in the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 6'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_idx <= word_index(haddr);
        end
    end

    wire logic wr_wake = wr_pend && (wr_idx == `MWCC_IDX_WAKE);
    wire logic wr_csum = wr_pend && (wr_idx == `MWCC_IDX_CSUM);
    wire logic wr_istat = wr_pend && (wr_idx == `MWCC_IDX_IRQ_STAT);
    wire logic wr_imask = wr_pend && (wr_idx == `MWCC_IDX_IRQ_MASK);
    wire logic rd_fwd = wr_pend && (wr_idx == word_index(haddr));

    // Event classification
    assign unicast_ev = rx_frame_done && !rx_dest_addr_bit0;
    assign wake_frame_ev = rx_frame_done && rx_wake_filter_match
        && wake_control_status[`MWCC_WFE_BIT];
    assign magic_ev = rx_magic_pkt_valid && wake_control_status[`MWCC_MPE_BIT];
    assign ev_vec = {unicast_ev && wake_control_status[`MWCC_GUE_BIT], magic_ev, wake_frame_ev};

    // Wake control: enables written, seen flags sticky, write one clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_control_status <= `MWCC_REG_RESET;
        end else begin
            if (wr_wake) begin
                wake_control_status[`MWCC_GUE_BIT] <= hwdata[`MWCC_GUE_BIT];
                wake_control_status[`MWCC_WFE_BIT] <= hwdata[`MWCC_WFE_BIT];
                wake_control_status[`MWCC_MPE_BIT] <= hwdata[`MWCC_MPE_BIT];
                if (hwdata[`MWCC_WFS_BIT]) begin
                    wake_control_status[`MWCC_WFS_BIT] <= 1'b0;
                end
                if (hwdata[`MWCC_MPS_BIT]) begin
                    wake_control_status[`MWCC_MPS_BIT] <= 1'b0;
                end
            end
            // Set wins over a clear in the same cycle
            if (wake_frame_ev) begin
                wake_control_status[`MWCC_WFS_BIT] <= 1'b1;
            end
            if (magic_ev) begin
                wake_control_status[`MWCC_MPS_BIT] <= 1'b1;
            end
        end
    end

    // Checksum control; reserved bits never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            checksum_offload_control <= `MWCC_REG_RESET;
        end else if (wr_csum) begin
            checksum_offload_control <= hwdata & `MWCC_CSUM_MASK;
        end
    end

    assign tx_csum_engine_en = checksum_offload_control[`MWCC_TXE_BIT];
    assign rx_csum_engine_en = checksum_offload_control[`MWCC_RXE_BIT];
    assign rx_csum_start_select = checksum_offload_control[`MWCC_RXSEL_BIT];
    // Zero here means the engine locates the layer-3 start itself
    assign rx_csum_fixed_start = rx_csum_start_select ? `MWCC_RX_START_L3
        : `MWCC_RX_START_L2;

    // Wake request held until power save is left
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_request <= 1'b0;
        end else if (!power_save) begin
            wake_request <= 1'b0;
        end else if (|ev_vec) begin
            wake_request <= 1'b1;
        end
    end

    // Interrupt status and mask
    assign w1c = wr_istat ? hwdata[2:0] : 3'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= `MWCC_REG_RESET;
        end else begin
            irq_stat <= {29'h0, (irq_stat[2:0] & ~w1c) | ev_vec};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= `MWCC_REG_RESET;
        end else if (wr_imask) begin
            irq_mask <= hwdata & `MWCC_IRQ_MASK;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data registered from the address phase
    // A read right behind a write to the same word sees the written result
    always_comb begin
        next_rdata = `MWCC_REG_RESET;
        unique case (word_index(haddr))
            `MWCC_IDX_WAKE: next_rdata = rd_fwd ? wake_merge(wake_control_status, hwdata)
                : wake_control_status & `MWCC_WAKE_RMASK;
            `MWCC_IDX_CSUM: next_rdata = rd_fwd ? hwdata & `MWCC_CSUM_MASK
                : checksum_offload_control;
            `MWCC_IDX_IRQ_STAT: next_rdata = rd_fwd ? irq_stat & ~hwdata
                : irq_stat;
            `MWCC_IDX_IRQ_MASK: next_rdata = rd_fwd ? hwdata & `MWCC_IRQ_MASK
                : irq_mask;
            `MWCC_IDX_CTRL_STAT: next_rdata = {28'h0, auto_pad_strip, rx_path_en,
                tx_path_en, power_save};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Assertions
    property p_gue_wake;
        @(posedge hclk) disable iff (!hresetn)
        power_save && rx_frame_done && !rx_dest_addr_bit0
        && wake_control_status[`MWCC_GUE_BIT] |=> wake_request || !power_save;
    endproperty
    a_gue_wake: assert property (p_gue_wake) else $error("unicast wake missed");

    property p_mc_unicast;
        @(posedge hclk) disable iff (!hresetn)
        rx_frame_done && rx_dest_addr_bit0 && !rx_magic_pkt_valid
        && !(rx_wake_filter_match && wake_control_status[`MWCC_WFE_BIT])
        |=> !irq_stat[`MWCC_IRQ_GU_BIT] || $past(irq_stat[`MWCC_IRQ_GU_BIT]);
    endproperty
    a_mc_unicast: assert property (p_mc_unicast) else $error("multicast seen as unicast");

    property p_wf_set;
        @(posedge hclk) disable iff (!hresetn)
        wake_frame_ev |=> wake_control_status[`MWCC_WFS_BIT];
    endproperty
    a_wf_set: assert property (p_wf_set) else $error("wake frame flag not set");

    property p_mp_set;
        @(posedge hclk) disable iff (!hresetn)
        rx_magic_pkt_valid && wake_control_status[`MWCC_MPE_BIT]
        |=> irq_stat[`MWCC_IRQ_MP_BIT] && wake_control_status[`MWCC_MPS_BIT];
    endproperty
    a_mp_set: assert property (p_mp_set) else $error("magic flag not set");

    property p_wf_off;
        @(posedge hclk) disable iff (!hresetn)
        !wake_control_status[`MWCC_WFS_BIT] && !wake_control_status[`MWCC_WFE_BIT]
        |=> !wake_control_status[`MWCC_WFS_BIT];
    endproperty
    a_wf_off: assert property (p_wf_off) else $error("wake frame flag while off");

    property p_mp_off;
        @(posedge hclk) disable iff (!hresetn)
        !wake_control_status[`MWCC_MPS_BIT] && !wake_control_status[`MWCC_MPE_BIT]
        |=> !wake_control_status[`MWCC_MPS_BIT];
    endproperty
    a_mp_off: assert property (p_mp_off) else $error("magic flag while off");

    property p_csum_out;
        @(posedge hclk) disable iff (!hresetn)
        wr_csum |=> tx_csum_engine_en == $past(hwdata[`MWCC_TXE_BIT])
        && rx_csum_engine_en == $past(hwdata[`MWCC_RXE_BIT]);
    endproperty
    a_csum_out: assert property (p_csum_out) else $error("engine enable mismatch");

    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        rx_csum_fixed_start == (rx_csum_start_select ? `MWCC_RX_START_L3 : `MWCC_RX_START_L2);
    endproperty
    a_start: assert property (p_start) else $error("start offset wrong");

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
        wake_control_status[`MWCC_WFS_BIT] && !(wr_wake && hwdata[`MWCC_WFS_BIT])
        |=> wake_control_status[`MWCC_WFS_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        (checksum_offload_control & ~`MWCC_CSUM_MASK) == 32'h0 && (wake_control_status
        & ~`MWCC_WAKE_RMASK) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_wake_drop;
        @(posedge hclk) disable iff (!hresetn)
        !power_save |=> !wake_request;
    endproperty
    a_wake_drop: assert property (p_wake_drop) else $error("wake not dropped");

    property p_wake_hold;
        @(posedge hclk) disable iff (!hresetn)
        wake_request && power_save |=> wake_request;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake lost");

    property p_gu_flag;
        @(posedge hclk) disable iff (!hresetn)
        rx_frame_done && !rx_dest_addr_bit0 && wake_control_status[`MWCC_GUE_BIT]
        |=> irq_stat[`MWCC_IRQ_GU_BIT];
    endproperty
    a_gu_flag: assert property (p_gu_flag) else $error("unicast event lost");

    property p_gu_off;
        @(posedge hclk) disable iff (!hresetn)
        !wake_control_status[`MWCC_GUE_BIT] && !irq_stat[`MWCC_IRQ_GU_BIT]
        |=> !irq_stat[`MWCC_IRQ_GU_BIT];
    endproperty
    a_gu_off: assert property (p_gu_off) else $error("unicast event while off");

    property p_wf_clr;
        @(posedge hclk) disable iff (!hresetn)
        wr_wake && hwdata[`MWCC_WFS_BIT] && !wake_frame_ev
        |=> !wake_control_status[`MWCC_WFS_BIT];
    endproperty
    a_wf_clr: assert property (p_wf_clr) else $error("wake frame flag kept");

    property p_mp_clr;
        @(posedge hclk) disable iff (!hresetn)
        wr_wake && hwdata[`MWCC_MPS_BIT] && !magic_ev
        |=> !wake_control_status[`MWCC_MPS_BIT];
    endproperty
    a_mp_clr: assert property (p_mp_clr) else $error("magic flag kept");

    property p_mp_sticky;
        @(posedge hclk) disable iff (!hresetn)
        wake_control_status[`MWCC_MPS_BIT] && !(wr_wake && hwdata[`MWCC_MPS_BIT])
        |=> wake_control_status[`MWCC_MPS_BIT];
    endproperty
    a_mp_sticky: assert property (p_mp_sticky) else $error("magic flag lost");

    property p_csum_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_csum |=> $stable(tx_csum_engine_en) && $stable(rx_csum_engine_en)
        && $stable(rx_csum_start_select);
    endproperty
    a_csum_hold: assert property (p_csum_hold) else $error("engine control moved");

    property p_irq_set;
        @(posedge hclk) disable iff (!hresetn)
        magic_ev && irq_mask[`MWCC_IRQ_MP_BIT] && !wr_imask |=> irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("magic irq missed");

    property p_rd_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && (word_index(haddr) == `MWCC_IDX_WAKE)
        |=> (hrdata & ~`MWCC_WAKE_RMASK) == 32'h0000_0000;
    endproperty
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bit read");

    // Main scenarios
    c_wake: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wake_request));
    c_magic: cover property (@(posedge hclk) disable iff (!hresetn) magic_ev);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_clr: cover property (@(posedge hclk) disable iff (!hresetn) wr_wake && wake_frame_ev);
    c_unicast: cover property (@(posedge hclk) disable iff (!hresetn) ev_vec[`MWCC_IRQ_GU_BIT]);
endmodule // mwcc_regs

`default_nettype wire

/* File: verif/mac_wake_and_csum_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mwcc_map.svh"
module mac_wake_and_csum_ctrl_tb;
    import mwcc_pkg::*;
    typedef struct {string name; mwcc_word_t exp;} mwcc_note_t;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    mwcc_word_t hwdata, hrdata, r, v, obs;
    logic fd, da0, wm, mp, ps, txp, rxp, pad, wreq, irq, txe, rxe, sel, rd_phase, pc;
    logic [7:0] fst;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h0000_ee4b;
    mwcc_note_t q[$];
    mwcc_note_t n;
    assign hready = hreadyout;
    assign obs = {18'h0, hresp, wreq, irq, txe, rxe, sel, fst};
    always #10 hclk = ~hclk;

    mwcc_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
        .hwdata, .hrdata, .hreadyout, .hresp, .rx_frame_done(fd), .rx_dest_addr_bit0(da0),
        .rx_wake_filter_match(wm), .rx_magic_pkt_valid(mp), .power_save(ps),
        .tx_path_en(txp), .rx_path_en(rxp), .auto_pad_strip(pad), .wake_request(wreq),
        .tx_csum_engine_en(txe), .rx_csum_engine_en(rxe), .rx_csum_start_select(sel),
        .rx_csum_fixed_start(fst), .irq(irq));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Port view: response (always OKAY), wake, irq, {tx en, rx en, select}, fixed start
    function automatic mwcc_word_t pv(logic w, logic i, logic [2:0] c);
        return {19'h0, w, i, c, c[0] ? 8'h00 : 8'h0e};
    endfunction

    task automatic bus(input logic w, input mwcc_idx_t idx, input mwcc_word_t d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `MWCC_HTRANS_NONSEQ;
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= ~w;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask

    task automatic wr(input mwcc_idx_t idx, input mwcc_word_t d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input string nm, input mwcc_idx_t idx, input mwcc_word_t e);
        q.push_back('{nm, e});
        bus(1'b0, idx, 32'h0);
    endtask

    task automatic pchk(input string nm, input mwcc_word_t e);
        q.push_back('{nm, e});
        @(posedge hclk);
        pc <= 1'b1;
        @(posedge hclk);
        pc <= 1'b0;
    endtask

    task automatic ev(input logic f, input logic a, input logic m, input logic g);
        @(posedge hclk);
        fd <= f;
        da0 <= a;
        wm <= m;
        mp <= g;
        @(posedge hclk);
        fd <= 1'b0;
        mp <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Oldest note against whatever result shows in this cycle
    always @(posedge hclk) begin
        if (rd_phase === 1'b1 || pc === 1'b1) begin
            n = q.pop_front();
            if (rd_phase === 1'b1) v = hrdata;
            else v = obs;
            check_count++;
            if (v !== n.exp) begin
                $display("mismatch %s exp %h seen %h", n.name, n.exp, v);
                n_fail++;
            end
        end
    end

    // Whole run is under two hundred cycles
    initial begin
        #40000;
        n_fail++;
        results();
    end

    initial begin
        {hsel, hwrite, fd, da0, wm, mp, ps, txp, rxp, pad, rd_phase, pc} = '0;
        haddr = '0;
        htrans = '0;
        hsize = `MWCC_HSIZE_WORD;
        hwdata = '0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd("wake_rst", `MWCC_IDX_WAKE, 32'h0);
        rd("csum_rst", `MWCC_IDX_CSUM, 32'h0);
        rd("stat_rst", `MWCC_IDX_IRQ_STAT, 32'h0);
        rd("mask_rst", `MWCC_IDX_IRQ_MASK, 32'h0);
        pchk("ports_rst", pv(1'b0, 1'b0, 3'h0));
        rd("unmapped", 6'h3f, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            {pad, rxp, txp} <= 3'h0;
            wr(`MWCC_IDX_WAKE, r);
            rd("wake_rw", `MWCC_IDX_WAKE, r & 32'h0000_0206);
            wr(`MWCC_IDX_CSUM, r);
            rd("csum_rw", `MWCC_IDX_CSUM, r & 32'h0001_0003);
            pchk("csum_ports", pv(1'b0, 1'b0, {r[16], r[0], r[1]}));
            {pad, rxp, txp, ps} <= {r[3] & ~r[0], r[2:0]};
            rd("ctrl_stat", `MWCC_IDX_CTRL_STAT, {28'h0, r[3] & ~r[0], r[2:0]});
        end
        {pad, rxp, txp, ps} <= 4'h0;
        wr(`MWCC_IDX_CSUM, 32'h0);
        wr(`MWCC_IDX_WAKE, 32'h0);
        $display("test fields done");
        ps <= 1'b1;
        ev(1'b1, 1'b0, 1'b1, 1'b1);
        rd("wake_off", `MWCC_IDX_WAKE, 32'h0);
        pchk("no_wake", pv(1'b0, 1'b0, 3'h0));
        wr(`MWCC_IDX_WAKE, 32'h0000_0002);
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd("magic", `MWCC_IDX_WAKE, 32'h0000_0022);
        pchk("magic_wake", pv(1'b1, 1'b0, 3'h0));
        rd("irq_magic", `MWCC_IDX_IRQ_STAT, 32'h0000_0002);
        wr(`MWCC_IDX_IRQ_MASK, 32'h0000_0007);
        pchk("irq_on", pv(1'b1, 1'b1, 3'h0));
        wr(`MWCC_IDX_IRQ_STAT, 32'h0000_0002);
        pchk("irq_clr", pv(1'b1, 1'b0, 3'h0));
        ps <= 1'b0;
        pchk("wake_drop", pv(1'b0, 1'b0, 3'h0));
        ps <= 1'b1;
        wr(`MWCC_IDX_WAKE, 32'h0000_0004);
        ev(1'b1, 1'b1, 1'b1, 1'b0);
        rd("wake_frame", `MWCC_IDX_WAKE, 32'h0000_0064);
        pchk("frame_wake", pv(1'b1, 1'b1, 3'h0));
        wr(`MWCC_IDX_WAKE, 32'h0000_0244);
        rd("wake_clr", `MWCC_IDX_WAKE, 32'h0000_0224);
        ps <= 1'b0;
        wr(`MWCC_IDX_IRQ_STAT, 32'h0000_0007);
        ps <= 1'b1;
        ev(1'b1, 1'b1, 1'b0, 1'b0);
        pchk("multicast", pv(1'b0, 1'b0, 3'h0));
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        pchk("unicast", pv(1'b1, 1'b1, 3'h0));
        rd("irq_unicast", `MWCC_IDX_IRQ_STAT, 32'h0000_0004);
        $display("test wake done");
        results();
    end
endmodule // mac_wake_and_csum_ctrl_tb
`default_nettype wire
